/* bench/ddn_partner.sv */
`timescale 1ns/100ps
// =====================================================================
// Far side: encoder sense line and brake driven from a terminal.
// =====================================================================
module ddn_partner (
   input  wire logic       clk,          // Drive clock.
   input  wire logic       shaft_fwd,    // True shaft sense from the bench.
   input  wire logic [3:0] terminal_out, // Output terminals of the drive.
   output logic            encoder_sense_raw,
   output logic            brake_open_r
);
   // The encoder reports shaft sense as a plain level.
   assign encoder_sense_raw = shaft_fwd;
   // Terminal 0 carries the torque flag and releases the brake.
   always_ff @(posedge clk) begin
      brake_open_r <= terminal_out[0];
   end
endmodule : ddn_partner

/* bench/testbench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end
// =====================================================================
// Self-checking bench for the detection and settings block.
// =====================================================================
module testbench;
   logic clk = 1'b0, reset = 1'b1, update_tick = 1'b0, drive_running = 1'b0, fwd = 1'b1;
   ddn_pkg::ddn_settings_type s;  // Operator settings.
   logic [31:0] term_sel = {8'h00, 8'h00, 8'h22, 8'h23}; // T0 torque, T1 low speed.
   ddn_pkg::ddn_method_type meth = ddn_pkg::DDN_VECTOR;
   ddn_pkg::ddn_kind_type   kind = ddn_pkg::DDN_SPEED;
   logic [8:0]  torque = 9'h000;
   logic [11:0] mspd = 12'h000, ospd = 12'h000, mon_in = 12'h000;
   logic [6:0]  flux = 7'h32;
   logic        sense, tf, lf, ne, fw, brake;
   logic [3:0]  tout;
   logic [4:0]  ndiv;
   logic [1:0]  ndep;
   logic [14:0] cnt;
   logic [6:0]  exc;
   logic [11:0] mon;
   int num_errors = 0, n_compared = 0;
   always #2 clk = ~clk;
   ddn_core i_dut (.clk(clk), .reset(reset), .settings(s), .output_terminal_function_sel(term_sel),
      .update_tick(update_tick), .drive_running(drive_running), .ctrl_method(meth),
      .ctrl_kind(kind), .output_torque(torque), .motor_speed(mspd), .output_speed(ospd),
      .encoder_sense_raw(sense), .flux_command(flux), .monitor_in(mon_in),
      .torque_threshold_flag(tf), .low_speed_flag(lf), .terminal_out(tout), .notch_enable(ne),
      .notch_divisor(ndiv), .notch_depth_sel(ndep), .encoder_counts_per_rev(cnt),
      .encoder_forward(fw), .excitation_ratio(exc), .analog_monitor_out_one(mon));
   ddn_partner i_far (.clk(clk), .shaft_fwd(fwd), .terminal_out(tout),
      .encoder_sense_raw(sense), .brake_open_r(brake));
   // One update pulse; flags are settled at the following falling edge.
   task automatic tick;
      @(negedge clk) update_tick = 1'b1;
      @(negedge clk) update_tick = 0;
   endtask : tick
   // Torque flag at equality and just below, and its terminal route.
   task automatic t_torque;
      torque = 9'h096; tick; `CHK(tf, 1'b1)
      @(negedge clk) `CHK(tout, 4'h1)
      @(negedge clk) `CHK(brake, 1'b1)
      torque = 9'h095; tick; `CHK(tf, 1'b0)
      torque = 9'h190; s.torque_threshold_setting = 9'h190; tick; `CHK(tf, 1'b1)
      @(negedge clk) s.torque_threshold_setting = 9'h096; torque = 0; tick;
      $display("test torque done");
   endtask : t_torque
   // Low speed flag under both methods and the zero setting.
   task automatic t_low;
      drive_running = 1; mspd = 12'h02D; tick; `CHK(lf, 1'b1)
      @(negedge clk) `CHK(tout, 4'h2)
      mspd = 12'h02E; tick; `CHK(lf, 1'b0)
      meth = ddn_pkg::DDN_VOLTS_HZ; ospd = 12'h02D; tick; `CHK(lf, 1'b1)
      ospd = 12'h02E; mspd = 0; tick; `CHK(lf, 1'b0)
      drive_running = 0; ospd = 0; tick; `CHK(lf, 1'b0)
      drive_running = 1; s.low_speed_threshold_setting = 0; tick; `CHK(lf, 1'b0)
      kind = ddn_pkg::DDN_POSITION; tick; `CHK(lf, 1'b1)
      kind = ddn_pkg::DDN_SPEED; meth = ddn_pkg::DDN_VECTOR;
      $display("test low speed done");
   endtask : t_low
   // Settings path: notch, encoder, excitation.
   task automatic t_set;
      @(negedge clk) s.notch_freq_code = 5'h1F; s.notch_depth_code = 2'h3;
      s.encoder_line_count = 13'h1000; s.encoder_direction_sel = 0;
      s.terminal_one_function_sel = 4'h1; s.excitation_ratio_setting = 7'h3C;
      @(negedge clk) @(negedge clk) `CHK(ne, 1'b1)
      `CHK(ndiv, 5'h1F)
      `CHK(ndep, 2'h3)
      `CHK(cnt, 15'h4000)
      `CHK(fw, 1'b0)
      `CHK(exc, 7'h32)
      kind = ddn_pkg::DDN_TORQUE;
      @(negedge clk) @(negedge clk) `CHK(ne, 1'b0)
      kind = ddn_pkg::DDN_SPEED;
      s.notch_freq_code = 0; s.terminal_one_function_sel = 0; s.encoder_direction_sel = 1;
      @(negedge clk) @(negedge clk) `CHK(ne, 1'b0)
      `CHK(exc, 7'h3C)
      `CHK(fw, 1'b1)
      s.monitor_filter_time = 0; mon_in = 12'hABC; tick; `CHK(mon, 12'hABC)
      $display("test settings done");
   endtask : t_set
   // Verdict and end of run.
   task automatic finish_test;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   initial begin
      s = '{13'h0400, 1'b1, 7'h64, 5'h00, 2'h0, 9'h096, 12'h02D, 9'h005, 4'h0};
      repeat (10) @(negedge clk);
      `CHK(tf, 1'b0)
      `CHK(cnt, 15'h1000)
      `CHK(exc, 7'h64)
      `CHK(ne, 1'b0)
      reset = 0;
      t_torque;
      t_low;
      t_set;
      finish_test;
   end
endmodule : testbench

/* verilog/ddn_core.sv */
`timescale 1ns/100ps
`include "ddn_map.svh"
// Overview of operation
// (RULE1) Torque flag on when torque reaches threshold.
// (RULE2) Torque flag off once torque below threshold.
// (RULE3) Terminal code 35 outputs torque flag.
// (RULE4) Vector running: low speed flag from motor speed.
// (RULE5) V/F running: compare output speed instead.
// (RULE6) Zero threshold: flag only in position control.
// (RULE7) Terminal code 34 outputs low speed flag.
// (RULE8) Notch code 0 off, n gives 1125/n Hz.
// (RULE9) Depth codes 0..3 map -40,-14,-8,-4 dB.
// (RULE10) Notch acts only in speed/position control.
// (RULE11) Line count times four gives counts.
// (RULE12) Direction bit chooses encoder rotation sense.
// (RULE13) Excitation ignored when terminal 1 is flux.
// (RULE14) Monitor output smoothed by settable filter.
// (RULE15) Comparators re-evaluated every update tick.
module ddn_core #(
   parameter int NTERM = 4,   // Number of output terminals.
   parameter int MW    = 12   // Analog monitor width.
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire ddn_pkg::ddn_settings_type settings,
   input  wire logic [NTERM*8-1:0]        output_terminal_function_sel,
   input  wire logic                      update_tick,
   input  wire logic                      drive_running,
   input  wire ddn_pkg::ddn_method_type   ctrl_method,
   input  wire ddn_pkg::ddn_kind_type     ctrl_kind,
   input  wire logic [8:0]                output_torque,
   input  wire logic [11:0]               motor_speed,
   input  wire logic [11:0]               output_speed,
   input  wire logic                      encoder_sense_raw,
   input  wire logic [6:0]                flux_command,
   input  wire logic [MW-1:0]             monitor_in,
   output logic                           torque_threshold_flag,
   output logic                           low_speed_flag,
   output logic [NTERM-1:0]               terminal_out,
   output logic                           notch_enable,
   output logic [4:0]                     notch_divisor,
   output logic [1:0]                     notch_depth_sel,
   output logic [14:0]                    encoder_counts_per_rev,
   output logic                           encoder_forward,
   output logic [6:0]                     excitation_ratio,
   output logic [MW-1:0]                  analog_monitor_out_one
);
   // =======================================================================
   // Detection comparators.
   // =======================================================================
   // Torque at or above threshold; the inverse clears the flag at the next update tick.
   wire torque_hit = output_torque >= settings.torque_threshold_setting; // [RULE1] [RULE2]
   // Vector control uses measured speed, V/F uses the output speed.
   wire [11:0] speed_seen = (ctrl_method == ddn_pkg::DDN_VECTOR) ?
                            motor_speed : output_speed; // [RULE4] [RULE5]
   wire thr_zero  = settings.low_speed_threshold_setting == 12'h000;
   wire slow_hit  = speed_seen <= settings.low_speed_threshold_setting;
   // A zero threshold confines the flag to position control.
   wire mode_ok   = !thr_zero || (ctrl_kind == ddn_pkg::DDN_POSITION); // [RULE6]
   wire slow_nxt  = drive_running && mode_ok && slow_hit; // [RULE4] [RULE5]

   logic torque_r;   // Torque flag.
   logic slow_r;     // Low speed flag.

   // Flags follow the comparators only on control update ticks, so a
   // crossing shows up at most one update period later.
   always_ff @(posedge clk) begin
      if (reset) begin
         torque_r <= 1'b0;
         slow_r   <= 1'b0;
      end else if (update_tick) begin // [RULE15]
         torque_r <= torque_hit;
         slow_r   <= slow_nxt;
      end
   end
   assign torque_threshold_flag = torque_r;
   assign low_speed_flag        = slow_r;

   // =======================================================================
   // Output terminal routing.
   // =======================================================================
   logic [NTERM-1:0] term_r;   // Registered terminal levels.
   logic [NTERM-1:0] term_nxt; // Selected flag per terminal.
   genvar g;
   generate
      for (g = 0; g < NTERM; g++) begin : g_term
         wire [7:0] code = output_terminal_function_sel[g*8 +: 8];
         // Unlisted codes belong to other functions and read low here.
         assign term_nxt[g] = (code == `DDN_TERM_TORQUE)    ? torque_r : // [RULE3]
                              (code == `DDN_TERM_LOW_SPEED) ? slow_r   : // [RULE7]
                              1'b0;
      end
   endgenerate

   // Terminals are one cycle behind the flags.
   always_ff @(posedge clk) begin
      if (reset) term_r <= '0;
      else       term_r <= term_nxt;
   end
   assign terminal_out = term_r;

   // =======================================================================
   // Notch, encoder and excitation settings handed to the control loops.
   // =======================================================================
   // The encoder sense line is a pin: it passes three stages, and a change
   // is taken only once the last two agree, so one metastable sample
   // cannot flip the reported rotation sense.
   logic sense_s1_r;   // First stage, read only by the second.
   logic sense_s2_r;   // Second stage.
   logic sense_s3_r;   // Third stage.
   logic sense_r;      // Accepted sense level.

   // Synchroniser and agreement filter for the encoder sense line.
   always_ff @(posedge clk) begin
      if (reset) begin
         sense_s1_r <= 1'b0;
         sense_s2_r <= 1'b0;
         sense_s3_r <= 1'b0;
         sense_r    <= 1'b0;
      end else begin
         sense_s1_r <= encoder_sense_raw;
         sense_s2_r <= sense_s1_r;
         sense_s3_r <= sense_s2_r;
         if (sense_s2_r == sense_s3_r) sense_r <= sense_s3_r;
      end
   end

   // Code n asks the loop for a centre of 1125 Hz divided by n.
   wire notch_kind = (ctrl_kind == ddn_pkg::DDN_SPEED) ||
                     (ctrl_kind == ddn_pkg::DDN_POSITION); // [RULE10]
   wire notch_nxt  = (settings.notch_freq_code != 5'h00) && notch_kind; // [RULE8]
   // Out-of-range setting is clipped rather than wrapped to a small count.
   wire [12:0] lines = (settings.encoder_line_count > `DDN_LINE_COUNT_MAX) ?
                       `DDN_LINE_COUNT_MAX : settings.encoder_line_count;
   wire [14:0] counts_nxt = {lines, 2'b00}; // [RULE11]
   wire        fwd_nxt = settings.encoder_direction_sel ?
                         sense_r : !sense_r; // [RULE12]
   wire        flux_sel = settings.terminal_one_function_sel == `DDN_FLUX_CMD_SEL;
   wire [6:0]  ex_set = (settings.excitation_ratio_setting > `DDN_EXCITE_MAX) ?
                        `DDN_EXCITE_MAX : settings.excitation_ratio_setting;
   wire [6:0]  ex_nxt = flux_sel ? flux_command : ex_set; // [RULE13]

   logic       notch_en_r;
   logic [4:0] notch_div_r;
   logic [1:0] depth_r;
   logic [14:0] counts_r;
   logic       fwd_r;
   logic [6:0] ex_r;

   // Registered so that every output comes from a flip-flop.
   always_ff @(posedge clk) begin
      if (reset) begin
         notch_en_r  <= 1'b0;
         notch_div_r <= 5'h00;
         depth_r     <= 2'h0;
         counts_r    <= {`DDN_LINE_COUNT_RST, 2'b00};
         fwd_r       <= `DDN_DIR_RST;
         ex_r        <= `DDN_EXCITE_RST;
      end else begin
         notch_en_r  <= notch_nxt;
         notch_div_r <= settings.notch_freq_code;
         depth_r     <= settings.notch_depth_code; // [RULE9]
         counts_r    <= counts_nxt;
         fwd_r       <= fwd_nxt;
         ex_r        <= ex_nxt;
      end
   end
   assign notch_enable           = notch_en_r;
   assign notch_divisor          = notch_div_r;
   assign notch_depth_sel        = depth_r;
   assign encoder_counts_per_rev = counts_r;
   assign encoder_forward        = fwd_r;
   assign excitation_ratio       = ex_r;

   // =======================================================================
   // First analog monitor smoothing.
   // =======================================================================
   // A first-order step y += (x-y)/8 is taken once every setting plus one ticks.
   // Trade-off: the shift keeps it multiplier free, at coarse steps.
   logic [MW-1:0] mon_r;
   logic [8:0]    step_cnt_r;
   wire           step_now = step_cnt_r >= settings.monitor_filter_time;
   wire signed [MW:0] diff = $signed({1'b0, monitor_in}) - $signed({1'b0, mon_r});
   wire signed [MW:0] delta = diff >>> `DDN_FILT_SHIFT;
   wire [MW-1:0]  mon_step = MW'(mon_r + delta[MW-1:0]);
   // Zero time passes the input through unfiltered.
   wire [MW-1:0]  mon_nxt = (settings.monitor_filter_time == 9'h000) ? monitor_in :
                           (diff != '0 && delta == '0) ? monitor_in : mon_step; // [RULE14]

   always_ff @(posedge clk) begin
      if (reset) begin
         mon_r      <= '0;
         step_cnt_r <= 9'h000;
      end else if (update_tick) begin
         step_cnt_r <= step_now ? 9'h000 : step_cnt_r + 9'h001;
         if (step_now) mon_r <= mon_nxt;
      end
   end
   assign analog_monitor_out_one = mon_r;

   // =======================================================================
   // Checks.
   // =======================================================================
   torque_on_a: assert property (@(posedge clk) disable iff (reset) // [RULE1]
      update_tick && output_torque >= settings.torque_threshold_setting
      |=> torque_threshold_flag) else $error("torque flag missed threshold");
   torque_off_a: assert property (@(posedge clk) disable iff (reset) // [RULE2]
      update_tick && output_torque < settings.torque_threshold_setting
      |=> !torque_threshold_flag) else $error("torque flag stuck on");
   term_torque_a: assert property (@(posedge clk) disable iff (reset) // [RULE3]
      output_terminal_function_sel[7:0] == `DDN_TERM_TORQUE
      |=> terminal_out[0] == $past(torque_threshold_flag))
      else $error("terminal not showing torque flag");
   slow_vec_a: assert property (@(posedge clk) disable iff (reset) // [RULE4]
      update_tick && drive_running && ctrl_method == ddn_pkg::DDN_VECTOR && !thr_zero
      |=> low_speed_flag == $past(motor_speed <= settings.low_speed_threshold_setting))
      else $error("vector low speed wrong");
   slow_vf_a: assert property (@(posedge clk) disable iff (reset) // [RULE5]
      update_tick && drive_running && ctrl_method == ddn_pkg::DDN_VOLTS_HZ && !thr_zero
      |=> low_speed_flag == $past(output_speed <= settings.low_speed_threshold_setting))
      else $error("v/f low speed wrong");
   slow_zero_a: assert property (@(posedge clk) disable iff (reset) // [RULE6]
      update_tick && thr_zero && ctrl_kind != ddn_pkg::DDN_POSITION
      |=> !low_speed_flag) else $error("low speed flag outside position");
   term_slow_a: assert property (@(posedge clk) disable iff (reset) // [RULE7]
      output_terminal_function_sel[7:0] == `DDN_TERM_LOW_SPEED
      |=> terminal_out[0] == $past(low_speed_flag))
      else $error("terminal not showing low speed flag");
   notch_off_a: assert property (@(posedge clk) disable iff (reset) // [RULE8]
      settings.notch_freq_code == 5'h00 |=> !notch_enable)
      else $error("notch on with code zero");
   notch_kind_a: assert property (@(posedge clk) disable iff (reset) // [RULE10]
      ctrl_kind == ddn_pkg::DDN_TORQUE |=> !notch_enable)
      else $error("notch on under torque control");
   excite_a: assert property (@(posedge clk) disable iff (reset) // [RULE13]
      flux_sel |=> excitation_ratio == $past(flux_command))
      else $error("excitation setting not ignored");
   hold_a: assert property (@(posedge clk) disable iff (reset) // [RULE15]
      !update_tick |=> $stable(torque_threshold_flag) && $stable(low_speed_flag))
      else $error("flag moved between ticks");

   torque_rise_c: cover property (@(posedge clk) $rose(torque_threshold_flag));
   slow_rise_c:   cover property (@(posedge clk) $rose(low_speed_flag));
   notch_c:       cover property (@(posedge clk) notch_enable && notch_depth_sel == 2'h3);
   term_c:        cover property (@(posedge clk) terminal_out[0] && update_tick);
endmodule : ddn_core

/* verilog/ddn_map.svh */
`ifndef DDN_MAP_SVH
`define DDN_MAP_SVH
// ==========================================================================
// Reset values, function codes and timing figures.
// ==========================================================================
`define DDN_TORQUE_THR_RST   9'h096
`define DDN_TORQUE_THR_MAX   9'h190
`define DDN_LOW_SPEED_RST    12'h02D
`define DDN_LOW_SPEED_MAX    12'hE10
`define DDN_LINE_COUNT_RST   13'h0400
`define DDN_LINE_COUNT_MAX   13'h1000
`define DDN_QUAD_SHIFT       2
`define DDN_DIR_RST          1'h1
`define DDN_EXCITE_RST       7'h64
`define DDN_EXCITE_MAX       7'h64
`define DDN_NOTCH_MAX        5'h1F
`define DDN_DEPTH_MAX        2'h3
`define DDN_FLUX_CMD_SEL     4'h1
`define DDN_TERM_LOW_SPEED   8'h22
`define DDN_TERM_TORQUE      8'h23
`define DDN_FILT_TIME_RST    9'h005
`define DDN_FILT_TIME_MAX    9'h1F4
`define DDN_FILT_SHIFT       3
`endif

/* verilog/ddn_pkg.sv */
package ddn_pkg;
   // =======================================================================
   // Control method and control kind.
   // =======================================================================
   typedef enum logic [0:0] {DDN_VECTOR, DDN_VOLTS_HZ} ddn_method_type;
   typedef enum logic [1:0] {DDN_SPEED, DDN_TORQUE, DDN_POSITION} ddn_kind_type;

   // Operator settings, carried together into the block.
   typedef struct packed {
      logic [12:0] encoder_line_count;           // Lines per revolution.
      logic        encoder_direction_sel;        // Rotation sense choice.
      logic [6:0]  excitation_ratio_setting;     // Percent.
      logic [4:0]  notch_freq_code;              // 0 disables the notch.
      logic [1:0]  notch_depth_code;             // 0 deepest, 3 shallowest.
      logic [8:0]  torque_threshold_setting;     // Percent.
      logic [11:0] low_speed_threshold_setting;  // r/min.
      logic [8:0]  monitor_filter_time;          // Units of 10 ms.
      logic [3:0]  terminal_one_function_sel;    // Terminal 1 use.
   } ddn_settings_type;
endpackage : ddn_pkg
